// >>> shared/srap_pkg.sv
// Constants, types and helpers of the serial register access interpreter
package srap_pkg;

   // Command byte fields
   localparam int CMD_OP_HI = 7;
   localparam int CMD_OP_LO = 6;
   localparam int CMD_LEN_HI = 5;
   localparam int CMD_LEN_LO = 4;
   localparam int CMD_ADDR_HI = 3;
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h2;

   // Fixed answer bytes
   localparam logic [7:0] RESP_CMD = 8'hc1;
   localparam logic [7:0] RESP_ADDR = 8'hc2;
   localparam logic [7:0] RESP_ACK = 8'h41;
   localparam logic [7:0] RESP_NACK = 8'h4e;

   // Address map
   localparam logic [11:0] ADDR_RAM_LAST = 12'h3ff;
   localparam logic [11:0] ADDR_COMMIT = 12'h900;
   localparam logic [11:0] ADDR_REFRESH = 12'ha00;
   localparam int RAM_BYTES = 1024;
   localparam logic [9:0] ADDR_STATUS = 10'h000;
   localparam logic [9:0] ADDR_TIMEOUT = 10'h080;
   localparam logic [9:0] ADDR_SHADOW_BASE = 10'h082;
   localparam int SHADOW_BYTES = 8;
   localparam int EXTERNAL_CLOCK_SELECT_BIT = 6;
   localparam int CHECKSUM_ENABLE_BIT = 7;

   // Hardware register reset values
   localparam logic [7:0] HW_BYTE_RESET = 8'h00;
   localparam logic EXTERNAL_CLOCK_SELECT_RESET = 1'b0;

   // Checksum x^8+x^5+x^4+1
   localparam logic [7:0] CRC_POLY = 8'h31;
   localparam logic [7:0] CRC_INIT = 8'h00;

   // Timing
   localparam int CLK_MHZ = 100;
   localparam int CYCLES_PER_MS = CLK_MHZ * 1000;
   localparam int TIMEOUT_MS = 200;

   typedef enum logic [7:0] {
      L_CMD = 8'h01,
      L_ADDR = 8'h02,
      L_WDATA = 8'h04,
      L_WCRC = 8'h08,
      L_WSYNC = 8'h10,
      L_RSYNC = 8'h20,
      L_RDATA = 8'h40,
      L_RCRC = 8'h80
   } srap_link_t;

   typedef enum logic [5:0] {
      J_IDLE = 6'h01,
      J_RAMRD = 6'h02,
      J_VIRT = 6'h04,
      J_RAMWR = 6'h08,
      J_COMMIT = 6'h10,
      J_REFRESH = 6'h20
   } srap_job_t;

   function automatic logic [7:0] srap_crc8(input logic [7:0] crc_in, input logic [7:0] data);
      logic [7:0] c;
      c = crc_in ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : srap_crc8

endpackage : srap_pkg

// >>> hw/srap_slave.sv
// Serial register access command interpreter, slave side
// Function
// R1 - One frame carries one read or one write of one register; the code takes a further command byte in the same frame.
// R2 - RAM registers are 16 or 32 bits, some writable, some read-only; the code lets the master write every RAM byte.
// R3 - Status RAM may be written both by internal logic and master.
// R4 - Virtual registers are read-only, four bytes, computed when read.
// R5 - Each hardware control register has a RAM shadow location.
// R6 - Reading A00h copies hardware registers into their RAM shadows.
// R7 - Reading 900h copies RAM shadows into the hardware registers.
// R8 - Command register reads trigger the copy; returned data is meaningless.
// R9 - Twelve-bit addresses; 000h-3FFh RAM, 400h-FFFh virtual and command.
// R10 - Full duplex: one byte back for every byte received.
// R11 - Multi-byte data moves least significant byte first.
// R12 - Command bits 7:6: 00 read, 10 write, others reserved.
// R13 - Command bits 5:4: 00 one, 01 two, 10 four bytes.
// R14 - Command bits 3:0 upper address, second byte lower address.
// R15 - Answer C1h during command byte, C2h during address byte.
// R16 - Sync bytes answer 4Eh while busy, 41h when done.
// R17 - Master clocks sync bytes until done, then collects data.
// R18 - Read with checksum enabled appends one checksum byte.
// R19 - Write data and checksum answered 41h, then sync bytes.
// R20 - Checksum over command to last data; mismatched write ignored.
// R21 - Stalled frame dropped after timeout; busy bytes ignored.
// R22 - Length code 11 selects an eight-byte transfer.
`timescale 1ns/100ps
`default_nettype none

module srap_slave #(
   parameter int CYCLES_PER_MS = srap_pkg::CYCLES_PER_MS,
   parameter int TIMEOUT_MS = srap_pkg::TIMEOUT_MS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic spi_sclk,
   input wire logic spi_ss_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   input wire logic int_wr_en,
   input wire logic [9:0] int_wr_addr,
   input wire logic [7:0] int_wr_data,
   output logic int_wr_ready,
   output logic virt_req,
   output logic [11:0] virt_addr,
   input wire logic virt_ack,
   input wire logic [31:0] virt_data,
   output logic [15:0] adc_config,
   output logic [15:0] adc_rate,
   output logic [15:0] adc_acquisition,
   output logic [15:0] serial_config,
   output logic external_clock_select,
   output logic link_busy
);

   // Pin synchronisers
   logic sclk_s1, sclk_s2, sclk_s3;
   logic ss_s1, ss_s2;
   logic mosi_s1, mosi_s2;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         ss_s1 <= 1'b1;
         ss_s2 <= 1'b1;
         mosi_s1 <= 1'b0;
         mosi_s2 <= 1'b0;
      end else begin
         sclk_s1 <= spi_sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         ss_s1 <= spi_ss_n;
         ss_s2 <= ss_s1;
         mosi_s1 <= spi_mosi;
         mosi_s2 <= mosi_s1;
      end
   end

   logic sclk_rise, sclk_fall, ss_act;
   assign sclk_rise = sclk_s2 & ~sclk_s3;
   assign sclk_fall = ~sclk_s2 & sclk_s3;
   assign ss_act = ~ss_s2;

   srap_pkg::srap_link_t link;
   srap_pkg::srap_job_t job;
   logic [7:0] ram [srap_pkg::RAM_BYTES];
   logic [7:0] rbuf [8];
   logic [7:0] wbuf [8];
   logic [7:0] hw [srap_pkg::SHADOW_BYTES];
   logic [2:0] bit_cnt;
   logic [7:0] rx_shift, rx_byte, tx_shift, next_tx;
   logic byte_done, ack_sent, timeout_hit;
   logic [7:0] cmd, crc;
   logic [11:0] addr;
   logic [3:0] idx, jidx, nbytes;
   logic job_start, job_wr, busy, crc_en;
   logic [1:0] op;

   assign op = cmd[srap_pkg::CMD_OP_HI:srap_pkg::CMD_OP_LO]; // R12
   assign nbytes = 4'(4'h1 << cmd[srap_pkg::CMD_LEN_HI:srap_pkg::CMD_LEN_LO]); // R13 R22
   assign busy = (job != srap_pkg::J_IDLE) | job_start;
   assign crc_en = ram[srap_pkg::ADDR_STATUS][srap_pkg::CHECKSUM_ENABLE_BIT];
   assign link_busy = busy;

   // Bit level: mode 0, sample on rising, shift on falling
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= 3'h0;
         rx_shift <= 8'h00;
         rx_byte <= 8'h00;
         byte_done <= 1'b0;
      end else begin
         byte_done <= 1'b0;
         if (!ss_act || timeout_hit) begin
            bit_cnt <= 3'h0;
         end else if (sclk_rise) begin
            rx_shift <= {rx_shift[6:0], mosi_s2};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
               rx_byte <= {rx_shift[6:0], mosi_s2};
               byte_done <= 1'b1;
            end
         end
      end
   end

   // Answer byte chosen from the current phase
   always_comb begin
      case (link)
         srap_pkg::L_CMD: next_tx = busy ? srap_pkg::RESP_NACK : srap_pkg::RESP_CMD; // R15 R21
         srap_pkg::L_ADDR: next_tx = srap_pkg::RESP_ADDR; // R15
         srap_pkg::L_WDATA: next_tx = srap_pkg::RESP_ACK; // R19
         srap_pkg::L_WCRC: next_tx = srap_pkg::RESP_ACK; // R19
         srap_pkg::L_WSYNC: next_tx = busy ? srap_pkg::RESP_NACK : srap_pkg::RESP_ACK; // R16 R19
         srap_pkg::L_RSYNC: next_tx = busy ? srap_pkg::RESP_NACK : srap_pkg::RESP_ACK; // R16
         srap_pkg::L_RDATA: next_tx = rbuf[idx[2:0]]; // R11
         srap_pkg::L_RCRC: next_tx = crc; // R18
         default: next_tx = srap_pkg::RESP_NACK;
      endcase
   end

   // Byte head reloads until the first rising edge, one byte out per byte in
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_shift <= srap_pkg::RESP_CMD;
         ack_sent <= 1'b0;
      end else if (bit_cnt == 3'h0 && !sclk_rise) begin
         tx_shift <= next_tx; // R10
         ack_sent <= (next_tx == srap_pkg::RESP_ACK);
      end else if (sclk_fall && bit_cnt != 3'h0) begin
         tx_shift <= {tx_shift[6:0], 1'b0};
      end
   end

   assign spi_miso = tx_shift[7];
   assign spi_miso_oe_n = ss_s2;

   // Frame sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link <= srap_pkg::L_CMD;
         cmd <= 8'h00;
         addr <= 12'h000;
         crc <= srap_pkg::CRC_INIT;
         idx <= 4'h0;
         job_start <= 1'b0;
         job_wr <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            wbuf[i] <= 8'h00;
         end
      end else begin
         job_start <= 1'b0;
         if (!ss_act || timeout_hit) begin
            link <= srap_pkg::L_CMD; // R1 R21
         end else if (byte_done) begin
            case (link)
               srap_pkg::L_CMD: begin
                  if (!busy) begin // R21
                     cmd <= rx_byte;
                     crc <= srap_pkg::srap_crc8(srap_pkg::CRC_INIT, rx_byte); // R20
                     link <= srap_pkg::L_ADDR;
                  end
               end
               srap_pkg::L_ADDR: begin
                  addr <= {cmd[srap_pkg::CMD_ADDR_HI:0], rx_byte}; // R14 R9
                  crc <= srap_pkg::srap_crc8(crc, rx_byte);
                  idx <= 4'h0;
                  if (op == srap_pkg::OP_READ) begin
                     job_start <= 1'b1;
                     job_wr <= 1'b0;
                     link <= srap_pkg::L_RSYNC;
                  end else if (op == srap_pkg::OP_WRITE) begin
                     link <= srap_pkg::L_WDATA;
                  end else begin
                     link <= srap_pkg::L_CMD; // R12
                  end
               end
               srap_pkg::L_WDATA: begin
                  wbuf[idx[2:0]] <= rx_byte; // R11
                  crc <= srap_pkg::srap_crc8(crc, rx_byte);
                  if (idx == nbytes - 4'h1) begin
                     if (crc_en) begin
                        link <= srap_pkg::L_WCRC;
                     end else begin
                        job_start <= 1'b1;
                        job_wr <= 1'b1;
                        link <= srap_pkg::L_WSYNC;
                     end
                  end else begin
                     idx <= idx + 4'h1;
                  end
               end
               srap_pkg::L_WCRC: begin
                  if (rx_byte == crc) begin // R20
                     job_start <= 1'b1;
                     job_wr <= 1'b1;
                  end
                  link <= srap_pkg::L_WSYNC;
               end
               srap_pkg::L_WSYNC: begin
                  if (ack_sent) begin
                     link <= srap_pkg::L_CMD;
                  end
               end
               srap_pkg::L_RSYNC: begin
                  if (ack_sent) begin // R17
                     idx <= 4'h0;
                     link <= srap_pkg::L_RDATA;
                  end
               end
               srap_pkg::L_RDATA: begin
                  crc <= srap_pkg::srap_crc8(crc, rbuf[idx[2:0]]);
                  if (idx == nbytes - 4'h1) begin
                     link <= crc_en ? srap_pkg::L_RCRC : srap_pkg::L_CMD; // R18
                  end else begin
                     idx <= idx + 4'h1;
                  end
               end
               srap_pkg::L_RCRC: link <= srap_pkg::L_CMD;
               default: link <= srap_pkg::L_CMD;
            endcase
         end
      end
   end

   // Register access engine
   logic [9:0] ram_idx, shadow_idx;
   logic job_last;
   assign ram_idx = 10'(addr[9:0] + 10'(jidx));
   assign shadow_idx = 10'(srap_pkg::ADDR_SHADOW_BASE + 10'(jidx));
   assign job_last = (jidx == nbytes - 4'h1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         job <= srap_pkg::J_IDLE;
         jidx <= 4'h0;
         for (int i = 0; i < 8; i++) begin
            rbuf[i] <= 8'h00;
         end
      end else begin
         case (job)
            srap_pkg::J_IDLE: begin
               jidx <= 4'h0;
               if (job_start) begin
                  if (addr <= srap_pkg::ADDR_RAM_LAST) begin // R9
                     job <= job_wr ? srap_pkg::J_RAMWR : srap_pkg::J_RAMRD; // R2
                  end else if (job_wr) begin
                     job <= srap_pkg::J_IDLE; // R4
                  end else begin
                     for (int i = 0; i < 8; i++) begin
                        rbuf[i] <= 8'h00; // R8
                     end
                     if (addr == srap_pkg::ADDR_COMMIT) begin
                        job <= srap_pkg::J_COMMIT; // R7
                     end else if (addr == srap_pkg::ADDR_REFRESH) begin
                        job <= srap_pkg::J_REFRESH; // R6
                     end else begin
                        job <= srap_pkg::J_VIRT; // R4
                     end
                  end
               end
            end
            srap_pkg::J_RAMRD: begin
               rbuf[jidx[2:0]] <= ram[ram_idx];
               jidx <= jidx + 4'h1;
               if (job_last) begin
                  job <= srap_pkg::J_IDLE;
               end
            end
            srap_pkg::J_VIRT: begin
               if (virt_ack) begin
                  for (int i = 0; i < 4; i++) begin
                     rbuf[i] <= virt_data[8*i +: 8]; // R4 R11
                  end
                  job <= srap_pkg::J_IDLE;
               end
            end
            srap_pkg::J_RAMWR: begin
               jidx <= jidx + 4'h1;
               if (job_last) begin
                  job <= srap_pkg::J_IDLE;
               end
            end
            srap_pkg::J_COMMIT, srap_pkg::J_REFRESH: begin
               jidx <= jidx + 4'h1;
               if (jidx == 4'(srap_pkg::SHADOW_BYTES)) begin
                  job <= srap_pkg::J_IDLE;
               end
            end
            default: job <= srap_pkg::J_IDLE;
         endcase
      end
   end

   assign virt_req = (job == srap_pkg::J_VIRT);
   assign virt_addr = addr;

   // Hardware registers, loaded from shadows
   logic shadow_step;
   assign shadow_step = jidx < 4'(srap_pkg::SHADOW_BYTES);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < srap_pkg::SHADOW_BYTES; i++) begin
            hw[i] <= srap_pkg::HW_BYTE_RESET;
         end
         external_clock_select <= srap_pkg::EXTERNAL_CLOCK_SELECT_RESET;
      end else if (job == srap_pkg::J_COMMIT) begin
         if (shadow_step) begin
            hw[jidx[2:0]] <= ram[shadow_idx]; // R5 R7
         end else begin
            external_clock_select <= ram[srap_pkg::ADDR_STATUS][srap_pkg::EXTERNAL_CLOCK_SELECT_BIT]; // R5 R7
         end
      end
   end

   assign adc_config = {hw[1], hw[0]};
   assign adc_rate = {hw[3], hw[2]};
   assign adc_acquisition = {hw[5], hw[4]};
   assign serial_config = {hw[7], hw[6]};

   // Register RAM: one write port, engine before internal logic
   logic [7:0] status_refresh;
   always_comb begin
      status_refresh = ram[srap_pkg::ADDR_STATUS];
      status_refresh[srap_pkg::EXTERNAL_CLOCK_SELECT_BIT] = external_clock_select;
   end
   assign int_wr_ready = (job != srap_pkg::J_RAMWR) && (job != srap_pkg::J_REFRESH);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < srap_pkg::RAM_BYTES; i++) begin
            ram[i] <= 8'h00;
         end
      end else if (job == srap_pkg::J_RAMWR) begin
         ram[ram_idx] <= wbuf[jidx[2:0]]; // R2 R3 R11
      end else if (job == srap_pkg::J_REFRESH) begin
         if (shadow_step) begin
            ram[shadow_idx] <= hw[jidx[2:0]]; // R6
         end else begin
            ram[srap_pkg::ADDR_STATUS] <= status_refresh; // R6
         end
      end else if (int_wr_en) begin
         ram[int_wr_addr] <= int_wr_data; // R3
      end
   end

   // Stalled frame watchdog
   logic [31:0] pre_cnt;
   logic [15:0] ms_cnt, timo_limit;
   assign timo_limit = ({ram[srap_pkg::ADDR_TIMEOUT + 10'h1], ram[srap_pkg::ADDR_TIMEOUT]} != 16'h0000) ?
      {ram[srap_pkg::ADDR_TIMEOUT + 10'h1], ram[srap_pkg::ADDR_TIMEOUT]} : 16'(TIMEOUT_MS);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt <= 32'h0;
         ms_cnt <= 16'h0;
         timeout_hit <= 1'b0;
      end else begin
         timeout_hit <= 1'b0;
         if (!ss_act || byte_done || timeout_hit || link == srap_pkg::L_CMD) begin
            pre_cnt <= 32'h0;
            ms_cnt <= 16'h0;
         end else if (pre_cnt == 32'(CYCLES_PER_MS - 1)) begin
            pre_cnt <= 32'h0;
            ms_cnt <= ms_cnt + 16'h1;
            if (ms_cnt + 16'h1 >= timo_limit) begin
               timeout_hit <= 1'b1; // R21
            end
         end else begin
            pre_cnt <= pre_cnt + 32'h1;
         end
      end
   end

endmodule : srap_slave

`default_nettype wire

// >>> verification/srap_properties.sv
// Port-level checks of the serial register interpreter
`timescale 1ns/100ps
`default_nettype none

module srap_properties #(
   parameter int CYCLES_PER_MS = 10,
   parameter int TIMEOUT_MS = 200
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic spi_ss_n,
   input wire logic spi_miso_oe_n,
   input wire logic int_wr_ready,
   input wire logic virt_req,
   input wire logic [11:0] virt_addr,
   input wire logic virt_ack,
   input wire logic [15:0] adc_config,
   input wire logic [15:0] adc_rate,
   input wire logic [15:0] adc_acquisition,
   input wire logic [15:0] serial_config,
   input wire logic external_clock_select,
   input wire logic link_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_ack;
      virt_req && virt_ack;
   endsequence
   sequence s_selected;
      !spi_ss_n [*4];
   endsequence
   sequence s_released;
      spi_ss_n [*3];
   endsequence

   a_drive_when_selected: assert property (s_selected |-> !spi_miso_oe_n)
      else $error("miso not driven while selected");
   a_float_when_released: assert property (s_released |-> spi_miso_oe_n)
      else $error("miso driven while released");
   a_virt_drops_after: assert property (s_ack |=> !virt_req)
      else $error("virtual request held after ack");
   a_virt_waits_ack: assert property (virt_req && !virt_ack |=> virt_req && $stable(virt_addr))
      else $error("virtual request not held");
   a_virt_addr_range: assert property (virt_req |-> virt_addr > srap_pkg::ADDR_RAM_LAST
         && virt_addr != srap_pkg::ADDR_COMMIT && virt_addr != srap_pkg::ADDR_REFRESH)
      else $error("virtual request for a non-virtual address");
   a_virt_means_busy: assert property (virt_req |-> link_busy)
      else $error("virtual wait while not busy");
   a_virt_then_idle: assert property ($fell(virt_req) |-> ##[0:20] !link_busy)
      else $error("engine still busy after virtual data");
   a_hw_by_engine: assert property ($changed({adc_config, adc_rate, adc_acquisition, serial_config,
         external_clock_select}) |-> $past(link_busy))
      else $error("hardware register changed outside a command");
   a_port_stall_busy: assert property (!int_wr_ready |-> link_busy)
      else $error("internal port stalled while idle");

   c_virt_ack: cover property (s_ack);
endmodule : srap_properties

bind srap_slave srap_properties #(.CYCLES_PER_MS(CYCLES_PER_MS), .TIMEOUT_MS(TIMEOUT_MS)) chk_u (
   .clk(clk), .rst_n(rst_n), .spi_ss_n(spi_ss_n), .spi_miso_oe_n(spi_miso_oe_n),
   .int_wr_ready(int_wr_ready), .virt_req(virt_req), .virt_addr(virt_addr), .virt_ack(virt_ack),
   .adc_config(adc_config), .adc_rate(adc_rate), .adc_acquisition(adc_acquisition),
   .serial_config(serial_config), .external_clock_select(external_clock_select), .link_busy(link_busy));

`default_nettype wire

// >>> verification/srap_master.sv
// Behavioural mode 0 serial master facing the interpreter
`timescale 1ns/100ps
`default_nettype none

module srap_master (
   output logic spi_sclk,
   output logic spi_ss_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   localparam realtime HALF = 62.5;

   initial begin
      spi_sclk = 1'b0;
      spi_ss_n = 1'b1;
      spi_mosi = 1'b0;
   end

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ((x << 1) ^ 8'h31) : (x << 1);
      end
      return x;
   endfunction : crc8

   // One byte each way, then a processing gap
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spi_mosi = tx[i];
         #HALF spi_sclk = 1'b1;
         rx[i] = spi_miso;
         #HALF spi_sclk = 1'b0;
      end
      spi_mosi = ~spi_mosi;
      #(4 * HALF);
   endtask : xfer

   // Lone byte, frame left open
   task automatic lone(input logic [7:0] tx);
      logic [7:0] rx;
      spi_ss_n = 1'b0;
      #501;
      xfer(tx, rx);
   endtask : lone

   // One register access per frame
   task automatic access(input logic wr, input logic [1:0] len, input logic [11:0] addr, input logic [63:0] wd,
         input logic crc_on, input logic bad, output logic [63:0] rd, output logic [15:0] hdr,
         output logic crc_ok, output logic done);
      logic [7:0] cmd;
      logic [7:0] r;
      logic [7:0] c;
      cmd = {wr ? 2'h2 : 2'h0, len, addr[11:8]};
      rd = '0;
      done = 1'b0;
      spi_ss_n = 1'b0;
      #501;
      xfer(cmd, hdr[15:8]);
      xfer(addr[7:0], hdr[7:0]);
      c = crc8(crc8(8'h00, cmd), addr[7:0]);
      for (int i = 0; wr && i < (1 << len); i++) begin
         xfer(wd[8 * i +: 8], r);
         c = crc8(c, wd[8 * i +: 8]);
      end
      if (wr && crc_on) begin
         xfer(c ^ {7'h00, bad}, r);
      end
      for (int k = 0; k < 40 && !done; k++) begin
         xfer(8'hff, r);
         done = (r === 8'h41);
      end
      for (int i = 0; !wr && i < (1 << len); i++) begin
         xfer(8'hff, r);
         rd[8 * i +: 8] = r;
         c = crc8(c, r);
      end
      crc_ok = 1'b1;
      if (!wr && crc_on) begin
         xfer(8'hff, r);
         crc_ok = (r === c);
      end
      #500;
      spi_ss_n = 1'b1;
      #500;
   endtask : access
endmodule : srap_master

`default_nettype wire

// >>> verification/srap_slave_test.sv
// Self-checking bench for the serial register interpreter
`timescale 1ns/100ps
`default_nettype none

module srap_slave_test;
   typedef struct packed {logic wr; logic [1:0] len; logic [11:0] addr; logic [63:0] data;} srap_row_t;
   localparam int TIMEOUT_CYCLES = 10 * 200;
   logic clk, rst_n, spi_sclk, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe_n, miso_line;
   logic int_wr_en, int_wr_ready, virt_req, virt_ack, external_clock_select, link_busy;
   logic [9:0] int_wr_addr;
   logic [7:0] int_wr_data;
   logic [11:0] virt_addr;
   logic [31:0] virt_data;
   logic [15:0] adc_config, adc_rate, adc_acquisition, serial_config, hdr;
   logic [63:0] rd;
   logic ok, done;
   int n_errors = 0;
   int n_compared = 0;
   srap_row_t rows [10] = '{
      '{1'b1, 2'h0, 12'h010, 64'ha5}, '{1'b0, 2'h0, 12'h010, 64'ha5},
      '{1'b1, 2'h1, 12'h020, 64'hbeef}, '{1'b0, 2'h1, 12'h020, 64'hbeef},
      '{1'b1, 2'h2, 12'h030, 64'h12345678}, '{1'b0, 2'h0, 12'h033, 64'h12},
      '{1'b1, 2'h3, 12'h040, 64'h0123456789abcdef}, '{1'b0, 2'h3, 12'h040, 64'h0123456789abcdef},
      '{1'b0, 2'h2, 12'h456, 64'h5a5a5456}, '{1'b0, 2'h3, 12'h456, 64'h5a5a5456}};

   srap_slave #(.CYCLES_PER_MS(10)) dut_u (.clk(clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .int_wr_en(int_wr_en),
      .int_wr_addr(int_wr_addr), .int_wr_data(int_wr_data), .int_wr_ready(int_wr_ready), .virt_req(virt_req),
      .virt_addr(virt_addr), .virt_ack(virt_ack), .virt_data(virt_data), .adc_config(adc_config),
      .adc_rate(adc_rate), .adc_acquisition(adc_acquisition), .serial_config(serial_config),
      .external_clock_select(external_clock_select), .link_busy(link_busy));
   srap_master m_u (.spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(miso_line));

   // Undriven line shows the opposite level
   assign miso_line = spi_miso_oe_n ? ~spi_miso : spi_miso;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Computing logic answers one cycle after the request
   always @(posedge clk) begin
      virt_ack <= virt_req && !virt_ack;
      virt_data <= {20'h5a5a5, virt_addr};
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic run(input logic wr, input logic [1:0] len, input logic [11:0] addr, input logic [63:0] wd,
         input logic cr = 1'b0, input logic bad = 1'b0);
      // Start offset keeps link edges off the system clock edge
      @(negedge clk);
      m_u.access(wr, len, addr, wd, cr, bad, rd, hdr, ok, done);
   endtask : run

   task automatic close_out;
      $display("errors %0d, comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out

   initial begin
      #600000;
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      close_out();
   end

   initial begin
      rst_n = 1'b0;
      int_wr_en = 1'b0;
      int_wr_addr = 10'h000;
      int_wr_data = 8'h00;
      repeat (10) @(posedge clk);
      chk({adc_config, adc_rate, adc_acquisition, serial_config}, 64'h0, "hw regs in reset");
      chk({external_clock_select, spi_miso_oe_n, virt_req, link_busy, int_wr_ready}, 5'b01001, "reset pins");
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      foreach (rows[j]) begin
         run(rows[j].wr, rows[j].len, rows[j].addr, rows[j].data);
         chk(hdr, 16'hc1c2, "header answer");
         chk(done, 1'b1, "sync done");
         if (!rows[j].wr) begin
            chk(rd, rows[j].data, "read data");
         end
      end
      run(1'b1, 2'h3, 12'h082, 64'h8877665544332211);
      run(1'b1, 2'h0, 12'h000, 64'h40);
      run(1'b0, 2'h0, 12'h900, 64'h0);
      chk(rd, 64'h0, "commit read data");
      chk({serial_config, adc_acquisition, adc_rate, adc_config}, 64'h8877665544332211, "commit");
      chk(external_clock_select, 1'b1, "commit clock select");
      run(1'b1, 2'h3, 12'h082, 64'h0);
      run(1'b0, 2'h0, 12'ha00, 64'h0);
      run(1'b0, 2'h3, 12'h082, 64'h0);
      chk(rd, 64'h8877665544332211, "refreshed shadows");
      run(1'b1, 2'h0, 12'h000, 64'h80);
      run(1'b1, 2'h1, 12'h050, 64'h1111, 1'b1);
      run(1'b1, 2'h1, 12'h050, 64'h2222, 1'b1, 1'b1);
      run(1'b0, 2'h1, 12'h050, 64'h0, 1'b1);
      chk(rd, 64'h1111, "bad checksum write");
      chk(ok, 1'b1, "read checksum");
      run(1'b1, 2'h0, 12'h000, 64'h0, 1'b1);
      @(posedge clk);
      int_wr_addr <= 10'h060;
      int_wr_data <= 8'h77;
      int_wr_en <= 1'b1;
      @(posedge clk);
      int_wr_en <= 1'b0;
      run(1'b0, 2'h0, 12'h060, 64'h0);
      chk(rd, 64'h77, "internal write");
      m_u.lone(8'h40);
      m_u.lone(8'h10);
      run(1'b0, 2'h0, 12'h010, 64'h0);
      chk({hdr, rd}, {16'hc1c2, 64'ha5}, "after reserved op");
      m_u.lone(8'h80);
      repeat (TIMEOUT_CYCLES + 500) @(posedge clk);
      run(1'b0, 2'h0, 12'h010, 64'h0);
      chk({hdr, rd}, {16'hc1c2, 64'ha5}, "after timeout");
      // Mid-run reset clears hardware registers and RAM
      rst_n <= 1'b0;
      @(posedge clk);
      chk({adc_config, adc_rate, adc_acquisition, serial_config}, 64'h0, "hw regs in second reset");
      chk(external_clock_select, 1'b0, "clock select in second reset");
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      run(1'b0, 2'h0, 12'h010, 64'h0);
      chk({hdr, rd}, {16'hc1c2, 64'h0}, "RAM after second reset");
      close_out();
   end
endmodule : srap_slave_test

`default_nettype wire
